// *** verilog/peripheral_power_gating.sv ***
// peripheral power gating: per-module clock gates and sleep enable logic
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

// Functional notes
// - bit 5 holds timer zero off
// - bit 3 holds timer one off
// - bit 4 always reads zero
// - bit 2 stops serial interface clock
// - bit 1 stops uart clock
// - comparator mux blocked while converter shut down
// - enabled converter stays on in sleep
// - first conversion after repower is extended
// - comparator off in deep sleep modes
// - internal reference kept while comparator enabled
// - fused supply monitor stays on in sleep
module peripheral_power_gating (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // peripheral state inputs
  input wire logic i_converter_enable,
  input wire logic i_conv_start,
  input wire logic i_comparator_enable,
  input wire logic i_comparator_use_mux,
  input wire logic i_comparator_use_ref,
  input wire logic [2:0] i_supply_monitor_level_fuses,
  // module clock enables
  output power_gating_pkg::module_clk_en_t o_clk_en,
  // analog helper enables
  output power_gating_pkg::analog_en_t o_analog
);

  logic [7:0] ctrl_q;
  logic [7:0] sleep_q;
  logic asleep;
  logic [2:0] mode;
  logic comp_allowed;
  logic conv_was_off_q;
  logic extended_q;
  logic monitor_fused;

  // ==========================================
  // address decode shared by the register write processes
  function automatic logic addr_is(input logic [3:0] addr, input logic [3:0] target);
    return addr == target;
  endfunction

  // ==========================================
  // register writes
  // reset clears power bits
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= power_gating_pkg::ctrl_reset;
    end else if (i_wr && addr_is(i_addr, power_gating_pkg::ctrl_offset)) begin
      ctrl_q <= i_wdata & power_gating_pkg::ctrl_write_mask;
    end
  end

  // sleep request and mode register
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sleep_q <= power_gating_pkg::sleep_reset;
    end else if (i_wr && addr_is(i_addr, power_gating_pkg::sleep_offset)) begin
      sleep_q <= {4'h0, i_wdata[3:0]};
    end
  end

  assign asleep = sleep_q[power_gating_pkg::sleep_req_bit];
  assign mode = sleep_q[power_gating_pkg::mode_lsb +: power_gating_pkg::mode_width];
  assign monitor_fused = (i_supply_monitor_level_fuses != 3'h7);

  // comparator allowed only awake, idle or noise reduction
  assign comp_allowed = !asleep || mode == 3'(power_gating_pkg::mode_idle) ||
                        mode == 3'(power_gating_pkg::mode_noise_reduce);

  // ==========================================
  // read data, one cycle after strobe
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        power_gating_pkg::ctrl_offset: o_rdata <= ctrl_q;
        power_gating_pkg::sleep_offset: o_rdata <= sleep_q;
        power_gating_pkg::status_offset: o_rdata <= {2'h0, extended_q, o_analog.supply_monitor_on,
                                                     o_analog.int_reference_on, o_analog.comparator_on,
                                                     o_analog.comparator_mux_ok, o_analog.converter_on};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ==========================================
  // module clock enables; gated modules keep their state, so they resume as before
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_clk_en <= '1;
    end else begin
      o_clk_en.timer_zero <= !ctrl_q[power_gating_pkg::timer_zero_bit];
      o_clk_en.timer_one <= !ctrl_q[power_gating_pkg::timer_one_bit];
      o_clk_en.serial_periph <= !ctrl_q[power_gating_pkg::serial_bit];
      o_clk_en.uart <= !ctrl_q[power_gating_pkg::uart_bit];
      // converter gate, software disables converter first
      o_clk_en.converter <= !ctrl_q[power_gating_pkg::converter_bit];
    end
  end

  // ==========================================
  // first conversion after repower is extended
  // remember off period, flag next start
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      conv_was_off_q <= 1'b1;
      extended_q <= 1'b0;
    end else begin
      if (!o_analog.converter_on) begin
        conv_was_off_q <= 1'b1;
      end else if (i_conv_start) begin
        conv_was_off_q <= 1'b0;
      end
      if (i_conv_start && o_analog.converter_on) begin
        extended_q <= conv_was_off_q;
      end
    end
  end

  // ==========================================
  // analog helper enables
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_analog <= '0;
    end else begin
      o_analog.converter_on <= i_converter_enable && !ctrl_q[power_gating_pkg::converter_bit];
      o_analog.comparator_on <= i_comparator_enable && comp_allowed;
      // mux blocked while converter shut down
      o_analog.comparator_mux_ok <= i_comparator_use_mux && !ctrl_q[power_gating_pkg::converter_bit];
      // reference follows comparator enable, not sleep
      o_analog.int_reference_on <= i_comparator_enable && i_comparator_use_ref;
      // fused monitor on in every mode
      o_analog.supply_monitor_on <= monitor_fused;
      o_analog.extended_conv <= extended_q;
    end
  end

  // ==========================================
  // assertions
  // timer zero gated one cycle after its bit rises
  a_timer_zero_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(ctrl_q[5]) |=> !o_clk_en.timer_zero)
    else $error("timer zero not gated");
  a_timer_one_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ctrl_q[3] && $past(ctrl_q[3]) |-> !o_clk_en.timer_one)
    else $error("timer one not gated");
  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_rd && i_addr == 4'h0 |=> o_rdata[4] == 1'b0)
    else $error("reserved bit read nonzero");
  a_serial_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_wr && i_addr == 4'h0 && i_wdata[2] |=> ##1 !o_clk_en.serial_periph)
    else $error("serial clock not stopped");
  a_uart_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_wr && i_addr == 4'h0 && !i_wdata[1] |=> ##1 o_clk_en.uart)
    else $error("uart clock not resumed");
  a_mux_blocked: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(ctrl_q[0]) |-> !o_analog.comparator_mux_ok)
    else $error("comparator mux used while converter off");
  a_comp_deep: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(asleep) && $past(mode) == 3'h2 |-> !o_analog.comparator_on)
    else $error("comparator on in power down");
  a_conv_sleep: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_converter_enable) && !$past(ctrl_q[0]) |-> o_analog.converter_on)
    else $error("converter dropped");
  a_ref_sleep: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_comparator_enable) && $past(i_comparator_use_ref) |-> o_analog.int_reference_on)
    else $error("reference dropped");
  a_monitor_on: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_supply_monitor_level_fuses) != 3'h7 |-> o_analog.supply_monitor_on)
    else $error("supply monitor dropped");
  a_reset_zero: assert property (@(posedge i_clk_sys)
    $fell(i_sys_rst) |-> ctrl_q == 8'h00)
    else $error("control not zero after reset");

  a_reset_clocks_run: assert property (@(posedge i_clk_sys)
    $fell(i_sys_rst) |-> o_clk_en == 5'h1f)
    else $error("module clocks not running after reset");

  a_timer_zero_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_clk_en.timer_zero != $past(ctrl_q[power_gating_pkg::timer_zero_bit]))
    else $error("timer zero enable does not track its bit");

  a_timer_one_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_clk_en.timer_one != $past(ctrl_q[power_gating_pkg::timer_one_bit]))
    else $error("timer one enable does not track its bit");

  a_serial_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_clk_en.serial_periph != $past(ctrl_q[power_gating_pkg::serial_bit]))
    else $error("serial enable does not track its bit");

  a_uart_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_clk_en.uart != $past(ctrl_q[power_gating_pkg::uart_bit]))
    else $error("uart enable does not track its bit");

  a_conv_clk_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_clk_en.converter != $past(ctrl_q[power_gating_pkg::converter_bit]))
    else $error("converter enable does not track its bit");

  a_bit4_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    ctrl_q[power_gating_pkg::reserved_bit] == 1'b0)
    else $error("reserved control bit stored");

  a_write_lands: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_wr) && $past(i_addr) == power_gating_pkg::ctrl_offset |->
    ctrl_q == ($past(i_wdata) & power_gating_pkg::ctrl_write_mask))
    else $error("control write not stored as masked");

  a_ctrl_read: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_rd) && $past(i_addr) == power_gating_pkg::ctrl_offset |-> o_rdata == $past(ctrl_q))
    else $error("control read data wrong");

  a_sleep_read: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_rd) && $past(i_addr) == power_gating_pkg::sleep_offset |-> o_rdata == $past(sleep_q))
    else $error("sleep read data wrong");

  a_sleep_upper: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    sleep_q[7:4] == 4'h0)
    else $error("sleep upper bits stored");

  a_status_top: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_rd) && $past(i_addr) == power_gating_pkg::status_offset |-> o_rdata[7:6] == 2'h0)
    else $error("status reserved bits nonzero");

  a_unmapped_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_rd) && $past(i_addr) > 4'h2 |-> o_rdata == 8'h00)
    else $error("unmapped read nonzero");

  a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data held past its cycle");

  a_mux_on: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_comparator_use_mux) && !$past(ctrl_q[0]) |-> o_analog.comparator_mux_ok)
    else $error("comparator mux withheld");

  a_conv_off_bit: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(ctrl_q[0]) |-> !o_analog.converter_on)
    else $error("converter on while shut down");

  a_conv_off_en: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !$past(i_converter_enable) |-> !o_analog.converter_on)
    else $error("converter on while disabled");

  a_comp_allowed: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_comparator_enable) && $past(comp_allowed) |-> o_analog.comparator_on)
    else $error("comparator dropped while allowed");

  a_comp_off_modes: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(asleep) && $past(mode) > 3'h1 |-> !o_analog.comparator_on)
    else $error("comparator on in deep sleep");

  a_comp_disabled: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !$past(i_comparator_enable) |-> !o_analog.comparator_on)
    else $error("comparator on while disabled");

  a_ref_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !$past(i_comparator_enable) |-> !o_analog.int_reference_on)
    else $error("reference on while comparator disabled");

  a_monitor_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_supply_monitor_level_fuses) == 3'h7 |-> !o_analog.supply_monitor_on)
    else $error("supply monitor on while not fused");

  a_off_marks: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(!o_analog.converter_on) |-> conv_was_off_q)
    else $error("off period not remembered");

  a_ext_first: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_conv_start) && $past(o_analog.converter_on) && $past(conv_was_off_q) |-> extended_q)
    else $error("first conversion not extended");

  a_ext_later: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_conv_start) && $past(o_analog.converter_on) && !$past(conv_was_off_q) |-> !extended_q)
    else $error("later conversion extended");

  a_ext_out: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_analog.extended_conv == $past(extended_q))
    else $error("extended output does not follow flag");

endmodule

// *** verilog/power_gating_pkg.sv ***
// package: register map, field positions and types for peripheral power gating
package power_gating_pkg;

  // ==========================================
  // register map
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] sleep_offset = 4'h1;
  localparam logic [3:0] status_offset = 4'h2;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] sleep_reset = 8'h00;

  // ==========================================
  // control field positions
  localparam int converter_bit = 0;
  localparam int uart_bit = 1;
  localparam int serial_bit = 2;
  localparam int timer_one_bit = 3;
  localparam int reserved_bit = 4;
  localparam int timer_zero_bit = 5;
  localparam logic [7:0] ctrl_write_mask = 8'h2f;

  // ==========================================
  // sleep register field positions
  localparam int sleep_req_bit = 0;
  localparam int mode_lsb = 1;
  localparam int mode_width = 3;

  // ==========================================
  // sleep modes
  typedef enum logic [2:0] {
    mode_idle = 3'h0,
    mode_noise_reduce = 3'h1,
    mode_power_down = 3'h2,
    mode_power_save = 3'h3,
    mode_standby = 3'h6,
    mode_ext_standby = 3'h7
  } sleep_mode_t;

  // ==========================================
  // per-module enables
  typedef struct packed {
    logic timer_zero;
    logic timer_one;
    logic serial_periph;
    logic uart;
    logic converter;
  } module_clk_en_t;

  // analog helper enables
  typedef struct packed {
    logic converter_on;
    logic comparator_on;
    logic comparator_mux_ok;
    logic int_reference_on;
    logic supply_monitor_on;
    logic extended_conv;
  } analog_en_t;

endpackage

// *** verif/peripheral_power_gating_test.sv ***
// testbench: register access and gating checks for peripheral power gating
`timescale 1ns/1ps
module peripheral_power_gating_test;
  // ==========================================
  // stimulus and observed signals
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic i_converter_enable = 1'b0;
  logic i_conv_start = 1'b0;
  logic i_comparator_enable = 1'b0;
  logic i_comparator_use_mux = 1'b0;
  logic i_comparator_use_ref = 1'b0;
  logic [2:0] i_supply_monitor_level_fuses = 3'h7;
  power_gating_pkg::module_clk_en_t o_clk_en;
  power_gating_pkg::analog_en_t o_analog;
  int errors = 0;
  int comparisons = 0;
  logic [7:0] rd;
  logic [7:0] v;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  logic comp;

  // 200 MHz system clock
  always #2.5 i_clk_sys = ~i_clk_sys;

  peripheral_power_gating i_dut (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_converter_enable(i_converter_enable),
    .i_conv_start(i_conv_start), .i_comparator_enable(i_comparator_enable),
    .i_comparator_use_mux(i_comparator_use_mux), .i_comparator_use_ref(i_comparator_use_ref),
    .i_supply_monitor_level_fuses(i_supply_monitor_level_fuses), .o_clk_en(o_clk_en), .o_analog(o_analog)
  );

  // ==========================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= addr;
    i_wdata <= data;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // read data is taken in the single cycle after the strobe
  task automatic reg_read(input logic [3:0] addr, output logic [7:0] data);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= addr;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    data = o_rdata;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conv_start();
    @(posedge i_clk_sys);
    i_conv_start <= 1'b1;
    @(posedge i_clk_sys);
    i_conv_start <= 1'b0;
    tick(2);
  endtask

  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    #100000;
    errors++;
    test_done();
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    tick(1);
    check({3'h0, o_clk_en}, 8'h1f);
    reg_read(power_gating_pkg::ctrl_offset, rd);
    check(rd, 8'h00);
    // no debug system here, serial bit free
    // serial side has no state to reinit
    // each control bit alone gates only its own module
    for (int i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      reg_write(power_gating_pkg::ctrl_offset, v);
      tick(2);
      check({3'h0, o_clk_en}, {3'h0, ~{v[5], v[3], v[2], v[1], v[0]}});
      reg_read(power_gating_pkg::ctrl_offset, rd);
      check(rd, v & 8'h2f);
      tick(1);
      check(o_rdata, 8'h00);
    end
    // clearing the bits lets every module run again
    reg_write(power_gating_pkg::ctrl_offset, 8'h00);
    tick(2);
    check({3'h0, o_clk_en}, 8'h1f);
    reg_read(4'h3, rd);
    check(rd, 8'h00);
    tick(1);
    check(o_rdata, 8'h00);
    // analog helpers across every sleep mode
    @(posedge i_clk_sys);
    i_converter_enable <= 1'b1;
    i_comparator_enable <= 1'b1;
    i_comparator_use_mux <= 1'b1;
    i_comparator_use_ref <= 1'b1;
    i_supply_monitor_level_fuses <= 3'h2;
    tick(2);
    check({3'h0, o_analog[5:1]}, 8'h1f);
    foreach (modes[m]) begin
      @(posedge i_clk_sys);
      i_comparator_enable <= (modes[m] != 3'h1);
      reg_write(power_gating_pkg::sleep_offset, {4'h0, modes[m], 1'b1});
      tick(2);
      comp = (modes[m] == 3'h0);
      check({4'h0, o_analog[5:4], o_analog[2:1]}, {4'h0, 1'b1, comp, modes[m] != 3'h1, 1'b1});
    end
    reg_write(power_gating_pkg::sleep_offset, 8'h00);
    @(posedge i_clk_sys);
    i_supply_monitor_level_fuses <= 3'h7;
    i_converter_enable <= 1'b0;
    reg_write(power_gating_pkg::ctrl_offset, 8'h01);
    tick(2);
    check({5'h0, o_analog[5], o_analog[3], o_analog[1]}, 8'h00);
    reg_write(power_gating_pkg::ctrl_offset, 8'h00);
    @(posedge i_clk_sys);
    i_converter_enable <= 1'b1;
    tick(3);
    check({7'h0, o_analog[3]}, 8'h01);
    // first start after re-powering is extended, the next is not
    conv_start();
    check({7'h0, o_analog[0]}, 8'h01);
    conv_start();
    check({7'h0, o_analog[0]}, 8'h00);
    @(posedge i_clk_sys);
    i_converter_enable <= 1'b0;
    tick(3);
    @(posedge i_clk_sys);
    i_converter_enable <= 1'b1;
    tick(3);
    conv_start();
    // status reflects helpers and ignores writes
    reg_write(power_gating_pkg::status_offset, 8'h00);
    reg_read(power_gating_pkg::status_offset, rd);
    check(rd, 8'h2f);
    test_done();
  end
endmodule
